// [bench/ptpsc_peer_model.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ptpsc_map.svh"

// ----------------------------------------
// far-side clocks on the network
// ----------------------------------------
// a remote master announces once per period on every port; with no master present,
// the announce-receipt timeout fires at the same pace instead
module ptpsc_peer_model #(
  parameter int ANN_PERIOD = 4
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic master_on,
  output logic [`PTPSC_NPORTS-1:0] ann_rx,
  output logic [`PTPSC_NPORTS-1:0] ann_timeout
);
  logic [7:0] cnt_r = 8'h00;

  always @(posedge clk) begin
    cnt_r <= (!nrst || cnt_r == 8'(ANN_PERIOD - 1)) ? 8'h00 : cnt_r + 8'h01;
  end

  // one-cycle pulses, so a port never sees a stale announce held across states
  assign ann_rx = {`PTPSC_NPORTS{master_on && cnt_r == 8'h00}};
  assign ann_timeout = {`PTPSC_NPORTS{!master_on && cnt_r == 8'h00}};
endmodule
`default_nettype wire

// [bench/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ptpsc_map.svh"

module tb;
  localparam int NP = `PTPSC_NPORTS;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic [1:0] mode = 2'h0;
  logic init_done = 1'h0, fault_unc = 1'h0, master_on = 1'h0;
  logic [NP-1:0] pfault = '0, perr = '0, pdis = '0, qual = '0, servo = '0, txq = '0, rxv = '0;
  logic [NP-1:0][1:0] bmc = '0;
  logic [NP-1:0][2:0] txc = '0, rxc = '0;
  logic [NP-1:0] ann_to, ann_rx, grant, acc, sync;
  logic [3:0] state;
  logic pen;
  int bad_count = 0;
  int cmp_count = 0;

  always #50 clk = ~clk;

  ptpsc_peer_model peer_u (.clk(clk), .nrst(nrst), .master_on(master_on), .ann_rx(ann_rx), .ann_timeout(ann_to));

  ptpsc_top dut_u (.clk(clk), .nrst(nrst), .time_protocol_mode_select(mode), .init_done(init_done),
    .fault_unconfined(fault_unc), .port_fault(pfault), .port_error(perr), .port_disable(pdis),
    .ann_timeout(ann_to), .ann_rx(ann_rx), .bmc_rec(bmc), .qual_done(qual), .servo_ready(servo),
    .tx_req(txq), .tx_class(txc), .rx_valid(rxv), .rx_class(rxc), .time_protocol_port_state(state),
    .proto_enabled_r(pen), .tx_grant_r(grant), .rx_accept_r(acc), .sync_active_r(sync));

  // ----------------------------------------
  // shared helpers
  // ----------------------------------------
  task step(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask

  task end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // status lags the state by one edge; six cycles also covers the announce period
  task st(input logic [3:0] e);
    step(6);
    chk(state, e);
  endtask

  // offers every message class back to back; bit c of m says whether class c passes
  task scan(input bit rx, input int p, input logic [5:0] m);
    for (int c = 0; c < 6; c++) begin
      if (rx) begin rxv[p] = 1'h1; rxc[p] = 3'(c); end
      else begin txq[p] = 1'h1; txc[p] = 3'(c); end
      step(1);
      chk(4'(rx ? acc[p] : grant[p]), 4'(m[c]));
    end
    if (rx) rxv[p] = 1'h0;
    else txq[p] = 1'h0;
  endtask

  task rst(input logic [1:0] m, input logic id, input logic mon);
    nrst = 1'h0;
    {pfault, perr, pdis, qual, servo, txq, rxv, fault_unc} = '0;
    bmc = '0;
    master_on = mon;
    mode = m;
    init_done = id;
    step(20);
    nrst = 1'h1;
    step(1);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task t_off;
    rst(`PTPSC_MODE_OFF, 1'h1, 1'h1);
    st(`PTPSC_RPT_DISABLED);
    chk(4'(pen), 4'h0);
    scan(0, 0, 6'h00);
    scan(1, 1, 6'h00);
    mode = 2'h3;
    st(`PTPSC_RPT_DISABLED);
    mode = `PTPSC_MODE_AUTO;
    st(`PTPSC_RPT_LISTEN);
    chk(4'(pen), 4'h1);
  endtask

  task t_init;
    rst(`PTPSC_MODE_AUTO, 1'h0, 1'h1);
    st(`PTPSC_RPT_INIT);
    scan(0, 0, 6'h00);
    scan(0, 1, 6'h00);
    init_done = 1'h1;
    st(`PTPSC_RPT_LISTEN);
    init_done = 1'h0;
    pfault[1] = 1'h1;
    step(3);
    pfault[1] = 1'h0;
    st(`PTPSC_RPT_INIT);
  endtask

  task t_listen;
    rst(`PTPSC_MODE_AUTO, 1'h1, 1'h1);
    st(`PTPSC_RPT_LISTEN);
    scan(0, 0, 6'h2C);
    bmc[0] = `PTPSC_BMC_PASSIVE;
    st(`PTPSC_RPT_PASSIVE);
    scan(0, 0, 6'h2C);
  endtask

  task t_master;
    rst(`PTPSC_MODE_AUTO, 1'h1, 1'h0);
    bmc[0] = `PTPSC_BMC_MASTER;
    st(`PTPSC_RPT_PEND_MASTER);
    scan(0, 0, 6'h3C);
    qual[0] = 1'h1;
    st(`PTPSC_RPT_MASTER);
    scan(0, 0, 6'h3F);
  endtask

  task t_roles;
    rst(`PTPSC_MODE_AUTO, 1'h1, 1'h1);
    step(6);
    master_on = 1'h0;
    bmc[0] = `PTPSC_BMC_MASTER;
    qual[0] = 1'h1;
    step(8);
    chk(state, `PTPSC_RPT_BEST_CLOCK);
    mode = `PTPSC_MODE_SLAVE;
    st(`PTPSC_RPT_LISTEN);
    st(`PTPSC_RPT_LISTEN);
    master_on = 1'h1;
    qual[0] = 1'h0;
    bmc[0] = `PTPSC_BMC_SLAVE;
    st(`PTPSC_RPT_UNCALIB);
    chk(4'(sync[0]), 4'h0);
    servo[0] = 1'h1;
    st(`PTPSC_RPT_SLAVE);
    chk(4'(sync[0]), 4'h1);
  endtask

  task t_fault;
    rst(`PTPSC_MODE_AUTO, 1'h1, 1'h1);
    pfault[0] = 1'h1;
    st(`PTPSC_RPT_FAULTY);
    scan(0, 0, 6'h20);
    scan(0, 1, 6'h2C);
    pfault[0] = 1'h0;
    fault_unc = 1'h1;
    st(`PTPSC_RPT_FAULTY);
    scan(0, 1, 6'h20);
  endtask

  task t_disable;
    rst(`PTPSC_MODE_AUTO, 1'h1, 1'h1);
    pdis[0] = 1'h1;
    st(`PTPSC_RPT_DISABLED);
    scan(0, 0, 6'h00);
    scan(1, 0, 6'h10);
    scan(0, 1, 6'h2C);
    perr[1] = 1'h1;
    st(`PTPSC_RPT_ERROR);
  endtask

  initial begin
    t_off();
    t_init();
    t_listen();
    t_master();
    t_roles();
    t_fault();
    t_disable();
    end_of_test();
  end

  // the scenarios take well under a thousand cycles
  initial begin
    step(3000);
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire

// [hdl/ptpsc_map.svh]
`ifndef PTPSC_MAP_SVH
`define PTPSC_MAP_SVH

// ----------------------------------------
// port count and mode select codes
// ----------------------------------------
`define PTPSC_NPORTS 2
`define PTPSC_MODE_OFF 2'h0
`define PTPSC_MODE_AUTO 2'h1
`define PTPSC_MODE_SLAVE 2'h2

// ----------------------------------------
// reported port state codes
// ----------------------------------------
`define PTPSC_RPT_INIT 4'h0
`define PTPSC_RPT_FAULTY 4'h1
`define PTPSC_RPT_DISABLED 4'h2
`define PTPSC_RPT_LISTEN 4'h3
`define PTPSC_RPT_PEND_MASTER 4'h4
`define PTPSC_RPT_MASTER 4'h5
`define PTPSC_RPT_PASSIVE 4'h6
`define PTPSC_RPT_UNCALIB 4'h7
`define PTPSC_RPT_SLAVE 4'h8
`define PTPSC_RPT_BEST_CLOCK 4'h9
`define PTPSC_RPT_ERROR 4'hA
`define PTPSC_RPT_RESET `PTPSC_RPT_DISABLED

// ----------------------------------------
// message classes
// ----------------------------------------
`define PTPSC_MSG_EVENT 3'h0
`define PTPSC_MSG_ANNOUNCE 3'h1
`define PTPSC_MSG_PDELAY 3'h2
`define PTPSC_MSG_SIGNAL 3'h3
`define PTPSC_MSG_MGMT 3'h4
`define PTPSC_MSG_MGMT_REPLY 3'h5

// ----------------------------------------
// best-master decision codes
// ----------------------------------------
`define PTPSC_BMC_NONE 2'h0
`define PTPSC_BMC_MASTER 2'h1
`define PTPSC_BMC_SLAVE 2'h2
`define PTPSC_BMC_PASSIVE 2'h3

`endif

// [hdl/ptpsc_pkg.sv]
package ptpsc_pkg;

  typedef enum logic [3:0] {
    PS_INIT,
    PS_FAULTY,
    PS_DISABLED,
    PS_LISTEN,
    PS_PEND_MASTER,
    PS_MASTER,
    PS_PASSIVE,
    PS_UNCALIB,
    PS_SLAVE
  } ptpsc_pstate_t;

endpackage

// [hdl/ptpsc_port_fsm.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ptpsc_map.svh"

module ptpsc_port_fsm
  import ptpsc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic proto_en,
  input wire logic slave_only,
  input wire logic hold_init,
  input wire logic force_fault,
  input wire logic fault,
  input wire logic disable_req,
  input wire logic init_done,
  input wire logic ann_timeout,
  input wire logic ann_rx,
  input wire logic [1:0] bmc_rec,
  input wire logic qual_done,
  input wire logic servo_ready,
  output var ptpsc_pstate_t state_r
);

  ptpsc_pstate_t state_nxt;
  logic running;

  assign running = (state_r == PS_LISTEN) || (state_r == PS_PEND_MASTER) || (state_r == PS_MASTER) ||
                   (state_r == PS_PASSIVE) || (state_r == PS_UNCALIB) || (state_r == PS_SLAVE);

  always_comb begin
    state_nxt = state_r;
    if (!proto_en) begin
      state_nxt = PS_DISABLED;
    end else if (force_fault || fault) begin
      state_nxt = PS_FAULTY;
    end else if (disable_req) begin
      state_nxt = PS_DISABLED;
    end else if (hold_init && state_r != PS_INIT && state_r != PS_FAULTY && state_r != PS_DISABLED) begin
      state_nxt = PS_INIT;
    end else if (slave_only && (state_r == PS_PEND_MASTER || state_r == PS_MASTER)) begin
      state_nxt = PS_LISTEN;
    end else begin
      unique case (state_r)
        PS_INIT: begin
          if (init_done) state_nxt = PS_LISTEN;
        end
        PS_FAULTY: begin
          state_nxt = PS_INIT;
        end
        PS_DISABLED: begin
          state_nxt = PS_INIT;
        end
        default: begin
          // a decision that matches the present role falls through, so qualify and servo steps still run
          if (running && bmc_rec == `PTPSC_BMC_SLAVE && ann_rx && state_r != PS_SLAVE &&
              state_r != PS_UNCALIB) begin
            state_nxt = PS_UNCALIB;
          end else if (running && bmc_rec == `PTPSC_BMC_MASTER && !slave_only && state_r != PS_MASTER &&
                       state_r != PS_PEND_MASTER) begin
            state_nxt = PS_PEND_MASTER;
          end else if (running && bmc_rec == `PTPSC_BMC_PASSIVE) begin
            state_nxt = PS_PASSIVE;
          end else if (state_r == PS_LISTEN && ann_timeout && !slave_only) begin
            state_nxt = PS_PEND_MASTER;
          end else if (state_r == PS_PEND_MASTER && qual_done) begin
            state_nxt = PS_MASTER;
          end else if (state_r == PS_UNCALIB && servo_ready) begin
            state_nxt = PS_SLAVE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_r <= PS_DISABLED;
    end else begin
      state_r <= state_nxt;
    end
  end

endmodule

`default_nettype wire

// [hdl/ptpsc_top.sv]
// How it works
// - mode off disables all protocol operation
// - automatic mode allows master or slave role
// - slave-only mode never takes master role
// - current state of port 0 always readable; other ports' states are not reported
// - initializing port transmits no messages
// - one port initializing holds all but faulty or disabled ports initializing
// - faulty port sends only management replies
// - unconfined fault makes all ports faulty
// - disabled port silent, accepts only management
// - disabled port never affects other ports
// - listening and passive send limited messages
// - pending master sends peer-delay, signaling, management
// - master port transmits without restriction
// - uncalibrated entered after selecting a master
// - slave state synchronizes to selected master
// - best clock only in automatic after master
// - any port error reports error status
`timescale 1ns/1ps
`default_nettype none
`include "ptpsc_map.svh"

module ptpsc_top
  import ptpsc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] time_protocol_mode_select,
  input wire logic init_done,
  input wire logic fault_unconfined,
  input wire logic [`PTPSC_NPORTS-1:0] port_fault,
  input wire logic [`PTPSC_NPORTS-1:0] port_error,
  input wire logic [`PTPSC_NPORTS-1:0] port_disable,
  input wire logic [`PTPSC_NPORTS-1:0] ann_timeout,
  input wire logic [`PTPSC_NPORTS-1:0] ann_rx,
  input wire logic [`PTPSC_NPORTS-1:0][1:0] bmc_rec,
  input wire logic [`PTPSC_NPORTS-1:0] qual_done,
  input wire logic [`PTPSC_NPORTS-1:0] servo_ready,
  input wire logic [`PTPSC_NPORTS-1:0] tx_req,
  input wire logic [`PTPSC_NPORTS-1:0][2:0] tx_class,
  input wire logic [`PTPSC_NPORTS-1:0] rx_valid,
  input wire logic [`PTPSC_NPORTS-1:0][2:0] rx_class,
  output logic [3:0] time_protocol_port_state,
  output logic proto_enabled_r,
  output logic [`PTPSC_NPORTS-1:0] tx_grant_r,
  output logic [`PTPSC_NPORTS-1:0] rx_accept_r,
  output logic [`PTPSC_NPORTS-1:0] sync_active_r
);

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  logic proto_en;
  logic slave_only;
  logic auto_mode;

  assign proto_en = time_protocol_mode_select == `PTPSC_MODE_AUTO ||
                    time_protocol_mode_select == `PTPSC_MODE_SLAVE;
  assign slave_only = time_protocol_mode_select == `PTPSC_MODE_SLAVE;
  assign auto_mode = time_protocol_mode_select == `PTPSC_MODE_AUTO;

  // ----------------------------------------
  // per-port state machines
  // ----------------------------------------
  ptpsc_pstate_t pstate [`PTPSC_NPORTS];
  logic [`PTPSC_NPORTS-1:0] in_init;
  logic [`PTPSC_NPORTS-1:0] in_slave_side;
  logic [`PTPSC_NPORTS-1:0] in_run;
  logic any_init;
  logic init_go;

  // a faulty or disabled port feeds nothing shared, so it stays confined
  assign any_init = |in_init;
  // ports leave initializing together and only when none is still running;
  // releasing per port would let a late joiner and a pulled-in port swap forever
  assign init_go = init_done && in_run == '0;

  // ----------------------------------------
  // message filter
  // ----------------------------------------
  function automatic logic tx_ok(input ptpsc_pstate_t s, input logic [2:0] c);
    logic lim;
    lim = c == `PTPSC_MSG_PDELAY || c == `PTPSC_MSG_SIGNAL || c == `PTPSC_MSG_MGMT_REPLY;
    tx_ok = 1'b0;
    unique case (s)
      PS_INIT: tx_ok = 1'b0;
      PS_DISABLED: tx_ok = 1'b0;
      PS_FAULTY: tx_ok = c == `PTPSC_MSG_MGMT_REPLY;
      PS_LISTEN: tx_ok = lim;
      PS_PASSIVE: tx_ok = lim;
      PS_PEND_MASTER: tx_ok = lim || c == `PTPSC_MSG_MGMT;
      PS_MASTER: tx_ok = 1'b1;
      PS_UNCALIB: tx_ok = 1'b1;
      PS_SLAVE: tx_ok = 1'b1;
    endcase
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `PTPSC_NPORTS; gi++) begin : g_port
      ptpsc_port_fsm u_fsm (
        .clk(clk),
        .nrst(nrst),
        .proto_en(proto_en),
        .slave_only(slave_only),
        .hold_init(any_init),
        .force_fault(fault_unconfined),
        .fault(port_fault[gi]),
        .disable_req(port_disable[gi]),
        .init_done(init_go),
        .ann_timeout(ann_timeout[gi]),
        .ann_rx(ann_rx[gi]),
        .bmc_rec(bmc_rec[gi]),
        .qual_done(qual_done[gi]),
        .servo_ready(servo_ready[gi]),
        .state_r(pstate[gi])
      );

      assign in_init[gi] = pstate[gi] == PS_INIT;
      assign in_slave_side[gi] = pstate[gi] == PS_UNCALIB || pstate[gi] == PS_SLAVE;
      assign in_run[gi] = !in_init[gi] && pstate[gi] != PS_FAULTY && pstate[gi] != PS_DISABLED;

      always_ff @(posedge clk) begin
        if (!nrst) begin
          tx_grant_r[gi] <= 1'b0;
        end else begin
          tx_grant_r[gi] <= proto_en && tx_req[gi] && tx_ok(pstate[gi], tx_class[gi]);
        end
      end

      always_ff @(posedge clk) begin
        if (!nrst) begin
          rx_accept_r[gi] <= 1'b0;
        end else if (pstate[gi] == PS_DISABLED) begin
          rx_accept_r[gi] <= proto_en && rx_valid[gi] && rx_class[gi] == `PTPSC_MSG_MGMT;
        end else begin
          rx_accept_r[gi] <= proto_en && rx_valid[gi];
        end
      end

      // servo tracks only once a master is selected and calibrated
      always_ff @(posedge clk) begin
        if (!nrst) begin
          sync_active_r[gi] <= 1'b0;
        end else begin
          sync_active_r[gi] <= proto_en && pstate[gi] == PS_SLAVE;
        end
      end

      init_silent_a: assert property (@(posedge clk) disable iff (!nrst)
        in_init[gi] |=> !tx_grant_r[gi]) else $error("initializing port granted transmit");
      faulty_tx_a: assert property (@(posedge clk) disable iff (!nrst)
        pstate[gi] == PS_FAULTY && tx_class[gi] != `PTPSC_MSG_MGMT_REPLY |=> !tx_grant_r[gi])
        else $error("faulty port sent non-reply message");
      disabled_rx_a: assert property (@(posedge clk) disable iff (!nrst)
        pstate[gi] == PS_DISABLED && rx_class[gi] != `PTPSC_MSG_MGMT |=> !rx_accept_r[gi])
        else $error("disabled port accepted protocol message");
      listen_tx_a: assert property (@(posedge clk) disable iff (!nrst)
        (pstate[gi] == PS_LISTEN || pstate[gi] == PS_PASSIVE) &&
        (tx_class[gi] == `PTPSC_MSG_EVENT || tx_class[gi] == `PTPSC_MSG_ANNOUNCE ||
         tx_class[gi] == `PTPSC_MSG_MGMT) |=> !tx_grant_r[gi])
        else $error("listening or passive port sent forbidden message");
      pend_master_a: assert property (@(posedge clk) disable iff (!nrst)
        pstate[gi] == PS_PEND_MASTER && (tx_class[gi] == `PTPSC_MSG_EVENT ||
        tx_class[gi] == `PTPSC_MSG_ANNOUNCE) |=> !tx_grant_r[gi])
        else $error("pending master sent timing message");
      master_tx_a: assert property (@(posedge clk) disable iff (!nrst)
        proto_en && pstate[gi] == PS_MASTER && tx_req[gi] |=> tx_grant_r[gi])
        else $error("master port transmit refused");
      slave_entry_a: assert property (@(posedge clk) disable iff (!nrst)
        pstate[gi] == PS_SLAVE && $past(pstate[gi]) != PS_SLAVE |-> $past(pstate[gi]) == PS_UNCALIB)
        else $error("slave entered without uncalibrated step");
      slave_only_a: assert property (@(posedge clk) disable iff (!nrst)
        slave_only |=> pstate[gi] != PS_MASTER && pstate[gi] != PS_PEND_MASTER)
        else $error("slave-only mode holds master role");
      unconfined_a: assert property (@(posedge clk) disable iff (!nrst)
        proto_en && fault_unconfined |=> pstate[gi] == PS_FAULTY)
        else $error("unconfined fault left port not faulty");
      // permitted traffic and role changes must still happen, not only forbidden ones stay out
      off_state_a: assert property (@(posedge clk) disable iff (!nrst)
        !proto_en |=> pstate[gi] == PS_DISABLED)
        else $error("port left disabled while protocol off");
      auto_master_a: assert property (@(posedge clk) disable iff (!nrst)
        proto_en && !slave_only && pstate[gi] == PS_LISTEN && bmc_rec[gi] == `PTPSC_BMC_MASTER &&
        !fault_unconfined && !port_fault[gi] && !port_disable[gi] && !any_init |=> pstate[gi] == PS_PEND_MASTER)
        else $error("automatic mode refused master role");
      disabled_tx_a: assert property (@(posedge clk) disable iff (!nrst)
        pstate[gi] == PS_DISABLED |=> !tx_grant_r[gi])
        else $error("disabled port granted transmit");
      disabled_mgmt_a: assert property (@(posedge clk) disable iff (!nrst)
        proto_en && pstate[gi] == PS_DISABLED && rx_valid[gi] && rx_class[gi] == `PTPSC_MSG_MGMT
        |=> rx_accept_r[gi])
        else $error("disabled port dropped management message");
      pend_grant_a: assert property (@(posedge clk) disable iff (!nrst)
        proto_en && pstate[gi] == PS_PEND_MASTER && tx_req[gi] && tx_class[gi] == `PTPSC_MSG_PDELAY
        |=> tx_grant_r[gi])
        else $error("pending master refused peer-delay message");
      uncalib_entry_a: assert property (@(posedge clk) disable iff (!nrst)
        pstate[gi] == PS_UNCALIB && $past(pstate[gi]) != PS_UNCALIB |-> $past(ann_rx[gi]))
        else $error("uncalibrated entered without announce");
      sync_idle_a: assert property (@(posedge clk) disable iff (!nrst)
        pstate[gi] != PS_SLAVE |=> !sync_active_r[gi])
        else $error("servo tracking outside slave state");
      sync_track_a: assert property (@(posedge clk) disable iff (!nrst)
        proto_en && pstate[gi] == PS_SLAVE |=> sync_active_r[gi])
        else $error("slave port not tracking master");
    end
  endgenerate

  // ----------------------------------------
  // status reporting
  // ----------------------------------------
  logic prior_master_r;
  logic [3:0] rpt_nxt;

  // remembers that some other clock on the network was master
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prior_master_r <= 1'b0;
    end else if (!auto_mode) begin
      prior_master_r <= 1'b0;
    end else if (|in_slave_side || |ann_rx) begin
      prior_master_r <= 1'b1;
    end
  end

  always_comb begin
    rpt_nxt = `PTPSC_RPT_INIT;
    unique case (pstate[0])
      PS_INIT: rpt_nxt = `PTPSC_RPT_INIT;
      PS_FAULTY: rpt_nxt = `PTPSC_RPT_FAULTY;
      PS_DISABLED: rpt_nxt = `PTPSC_RPT_DISABLED;
      PS_LISTEN: rpt_nxt = `PTPSC_RPT_LISTEN;
      PS_PEND_MASTER: rpt_nxt = `PTPSC_RPT_PEND_MASTER;
      PS_MASTER: rpt_nxt = `PTPSC_RPT_MASTER;
      PS_PASSIVE: rpt_nxt = `PTPSC_RPT_PASSIVE;
      PS_UNCALIB: rpt_nxt = `PTPSC_RPT_UNCALIB;
      PS_SLAVE: rpt_nxt = `PTPSC_RPT_SLAVE;
    endcase
    if (!proto_en) begin
      rpt_nxt = `PTPSC_RPT_DISABLED;
    end else if (|port_error) begin
      rpt_nxt = `PTPSC_RPT_ERROR;
    end else if (auto_mode && prior_master_r && pstate[0] == PS_MASTER) begin
      rpt_nxt = `PTPSC_RPT_BEST_CLOCK;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      time_protocol_port_state <= `PTPSC_RPT_RESET;
    end else begin
      time_protocol_port_state <= rpt_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      proto_enabled_r <= 1'b0;
    end else begin
      proto_enabled_r <= proto_en;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  off_tx_block_a: assert property (@(posedge clk) disable iff (!nrst)
    !proto_en |=> tx_grant_r == '0 && rx_accept_r == '0 && !proto_enabled_r)
    else $error("traffic passed while protocol off");
  off_report_a: assert property (@(posedge clk) disable iff (!nrst)
    !proto_en |=> time_protocol_port_state == `PTPSC_RPT_DISABLED)
    else $error("off mode not reported disabled");
  error_report_a: assert property (@(posedge clk) disable iff (!nrst)
    proto_en && |port_error |=> time_protocol_port_state == `PTPSC_RPT_ERROR)
    else $error("port error not reported");
  best_clock_a: assert property (@(posedge clk) disable iff (!nrst)
    time_protocol_port_state == `PTPSC_RPT_BEST_CLOCK |-> $past(auto_mode) && $past(prior_master_r))
    else $error("best clock reported without cause");
  init_spread_a: assert property (@(posedge clk) disable iff (!nrst)
    proto_en && any_init && !fault_unconfined && port_fault == '0 && port_disable == '0 && !init_done
    ##1 proto_en |-> in_init == '1)
    else $error("initializing not spread to all ports");
  report_track_a: assert property (@(posedge clk) disable iff (!nrst)
    proto_en && port_error == '0 && pstate[0] == PS_SLAVE |=> time_protocol_port_state == `PTPSC_RPT_SLAVE)
    else $error("status does not follow port state");
  // the report trails the state by one edge, so role checks look two edges on
  enable_flag_a: assert property (@(posedge clk) disable iff (!nrst)
    proto_en |=> proto_enabled_r)
    else $error("enabled mode not flagged");
  slave_report_a: assert property (@(posedge clk) disable iff (!nrst)
    slave_only ##1 slave_only |=> time_protocol_port_state != `PTPSC_RPT_MASTER &&
    time_protocol_port_state != `PTPSC_RPT_PEND_MASTER && time_protocol_port_state != `PTPSC_RPT_BEST_CLOCK)
    else $error("slave-only mode reported master role");
  prior_clear_a: assert property (@(posedge clk) disable iff (!nrst)
    !auto_mode |=> !prior_master_r)
    else $error("prior master kept outside automatic mode");
  init_release_a: assert property (@(posedge clk) disable iff (!nrst)
    proto_en && init_go && in_init == '1 && !fault_unconfined && port_fault == '0 && port_disable == '0
    |=> in_init == '0)
    else $error("ports did not leave initializing together");

endmodule

`default_nettype wire
